// ### pkg/dwp_params.svh
// ----------------------------------------------------------------
// Overview of operation
// - Address byte: prefix 01011, two bits, R/W
// - Address bits must equal both strap pins
// - R/W high reads, low writes
// - Write: instruction byte follows, acknowledged
// - Wiper select picks first or second register
// - Midscale bit loads selected wiper with midscale
// - Soft shutdown bit acts like shutdown pin
// - Logic output bits latched onto output pins
// - Data byte acknowledged, stored in selected wiper
// - Read returns wiper chosen by last write
// - Shutdown pin shorts wiper, keeps stored codes
// ----------------------------------------------------------------
`ifndef DWP_PARAMS_SVH
`define DWP_PARAMS_SVH

// ----------------------------------------------------------------
// Bus framing
// ----------------------------------------------------------------
`define DWP_ADDR_PREFIX 5'h0B
`define DWP_INS_WSEL 7
`define DWP_INS_MID 6
`define DWP_INS_SD 5
`define DWP_INS_OUT1 4
`define DWP_INS_OUT2 3
`define DWP_MIDSCALE 8'h80
`define DWP_WIPER_RST 8'h80

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DWP_CLK_NS 20
`define DWP_QTR_NS 650
`define DWP_QTR_CYC ((`DWP_QTR_NS + `DWP_CLK_NS - 1) / `DWP_CLK_NS)

// ----------------------------------------------------------------
// Controller registers
// ----------------------------------------------------------------
`define DWP_OFF_CTRL 8'h00
`define DWP_OFF_INSTR 8'h04
`define DWP_OFF_WDATA 8'h08
`define DWP_OFF_STATUS 8'h0C
`define DWP_CTRL_GO 0
`define DWP_CTRL_RW 1
`define DWP_CTRL_ALO 2
`define DWP_CTRL_AHI 3
`define DWP_ST_BUSY 0
`define DWP_ST_NACK 1

`endif

// ### pkg/dwp_pkg.sv
package dwp_pkg;
  typedef logic [7:0] dwp_byte_t;
  typedef enum logic [2:0] {
    dwp_d_idle = 3'h0,
    dwp_d_addr = 3'h1,
    dwp_d_instr = 3'h3,
    dwp_d_data = 3'h2,
    dwp_d_read = 3'h6,
    dwp_d_skip = 3'h7
  } dwp_dev_state_e;
  typedef enum logic [1:0] {
    dwp_m_idle = 2'h0,
    dwp_m_start = 2'h1,
    dwp_m_bits = 2'h3,
    dwp_m_stop = 2'h2
  } dwp_mst_state_e;
endpackage

// ### pkg/dwp_i2c_if.sv
`timescale 1ns/1ps
interface dwp_i2c_if;
  logic m_scl_o;
  logic m_scl_oe_n;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic s_sda_o;
  logic s_sda_oe_n;
  logic scl;
  logic sda;
  // Open-drain wired AND, idle level pulled high
  assign scl = ~(~m_scl_oe_n & ~m_scl_o);
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~s_sda_oe_n & ~s_sda_o));
  modport master (output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n, input scl, input sda);
  modport device (output s_sda_o, output s_sda_oe_n, input scl, input sda);
endinterface

// ### rtl/dwp_i2c_device.sv
`timescale 1ns/1ps
`include "dwp_params.svh"
module dwp_i2c_device (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Two-wire bus
  dwp_i2c_if.device bus,
  // Strap and shutdown pins
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  input wire logic shutdown_pin_n,
  // Wiper registers
  output dwp_pkg::dwp_byte_t wiper_reg_first,
  output dwp_pkg::dwp_byte_t wiper_reg_second,
  output logic wiper_select,
  // Logic outputs and shutdown
  output logic logic_out_first,
  output logic logic_out_second,
  output logic soft_shutdown_bit,
  output logic shutdown_active
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pins_in;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic scl_q_reg;
  logic sda_q_reg;
  logic scl_s;
  logic sda_s;
  logic strap_hi_s;
  logic strap_lo_s;
  logic shutdown_pin_n_n_s;

  assign pins_in = {shutdown_pin_n, addr_strap_lo, addr_strap_hi, bus.sda, bus.scl};
  assign scl_s = sync2_reg[0];
  assign sda_s = sync2_reg[1];
  assign strap_hi_s = sync2_reg[2];
  assign strap_lo_s = sync2_reg[3];
  assign shutdown_pin_n_n_s = sync2_reg[4];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 5'h13;
      sync2_reg <= 5'h13;
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_s & ~scl_q_reg;
  assign scl_fall = ~scl_s & scl_q_reg;
  assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  dwp_pkg::dwp_dev_state_e state_reg;
  dwp_pkg::dwp_dev_state_e state_next;
  logic [3:0] bitcnt_reg;
  dwp_pkg::dwp_byte_t shift_reg;
  dwp_pkg::dwp_byte_t tx_reg;
  dwp_pkg::dwp_byte_t rd_byte;
  logic rw_reg;
  logic hit_reg;
  logic mack_reg;
  logic byte_done;
  logic ack_end;
  logic drive_low_reg;

  assign byte_done = scl_fall && (bitcnt_reg == 4'h8);
  assign ack_end = scl_fall && (bitcnt_reg == 4'h9);
  assign rd_byte = wiper_select ? wiper_reg_second : wiper_reg_first;

  function automatic logic addr_match(input dwp_pkg::dwp_byte_t b, input logic hi, input logic lo);
    addr_match = (b[7:3] == `DWP_ADDR_PREFIX) && (b[2] == hi) && (b[1] == lo);
  endfunction

  always_comb begin
    case (state_reg)
      dwp_pkg::dwp_d_addr: begin
        if (!hit_reg) begin
          state_next = dwp_pkg::dwp_d_skip;
        end else if (rw_reg) begin
          state_next = dwp_pkg::dwp_d_read;
        end else begin
          state_next = dwp_pkg::dwp_d_instr;
        end
      end
      dwp_pkg::dwp_d_instr: begin
        state_next = dwp_pkg::dwp_d_data;
      end
      dwp_pkg::dwp_d_read: begin
        state_next = mack_reg ? dwp_pkg::dwp_d_read : dwp_pkg::dwp_d_skip;
      end
      default: begin
        state_next = dwp_pkg::dwp_d_skip;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dwp_pkg::dwp_d_idle;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (start_det) begin
      state_reg <= dwp_pkg::dwp_d_addr;
      bitcnt_reg <= 4'h0;
    end else if (stop_det) begin
      state_reg <= dwp_pkg::dwp_d_idle;
      bitcnt_reg <= 4'h0;
    end else if (state_reg != dwp_pkg::dwp_d_idle) begin
      if (scl_rise && bitcnt_reg < 4'h8) begin
        shift_reg <= {shift_reg[6:0], sda_s};
        bitcnt_reg <= bitcnt_reg + 4'h1;
      end else if (scl_rise && bitcnt_reg == 4'h8) begin
        bitcnt_reg <= 4'h9;
      end else if (ack_end) begin
        bitcnt_reg <= 4'h0;
        state_reg <= state_next;
      end
    end
  end

  // Address result and read acknowledge from the master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rw_reg <= 1'h0;
      hit_reg <= 1'h0;
      mack_reg <= 1'h0;
    end else begin
      if (byte_done && state_reg == dwp_pkg::dwp_d_addr) begin
        hit_reg <= addr_match(shift_reg, strap_hi_s, strap_lo_s);
        rw_reg <= shift_reg[0];
      end
      if (scl_rise && bitcnt_reg == 4'h8 && state_reg == dwp_pkg::dwp_d_read) begin
        mack_reg <= ~sda_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // SDA driver
  // ----------------------------------------------------------------
  // SDA only moves after SCL falls, so no false start or stop is made
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_low_reg <= 1'h0;
      tx_reg <= 8'h00;
    end else if (start_det || stop_det) begin
      drive_low_reg <= 1'h0;
    end else if (byte_done) begin
      case (state_reg)
        dwp_pkg::dwp_d_addr: drive_low_reg <= addr_match(shift_reg, strap_hi_s, strap_lo_s);
        dwp_pkg::dwp_d_instr: drive_low_reg <= 1'h1;
        dwp_pkg::dwp_d_data: drive_low_reg <= 1'h1;
        default: drive_low_reg <= 1'h0;
      endcase
    end else if (ack_end) begin
      if (state_next == dwp_pkg::dwp_d_read) begin
        tx_reg <= rd_byte;
        drive_low_reg <= ~rd_byte[7];
      end else begin
        drive_low_reg <= 1'h0;
      end
    end else if (scl_fall && state_reg == dwp_pkg::dwp_d_read && bitcnt_reg != 4'h0 && bitcnt_reg < 4'h8) begin
      drive_low_reg <= ~tx_reg[6];
      tx_reg <= {tx_reg[6:0], 1'h0};
    end
  end

  assign bus.s_sda_o = 1'h0;
  assign bus.s_sda_oe_n = ~drive_low_reg;

  // ----------------------------------------------------------------
  // Instruction and data effects
  // ----------------------------------------------------------------
  logic instr_take;
  logic data_take;

  assign instr_take = byte_done && state_reg == dwp_pkg::dwp_d_instr;
  assign data_take = byte_done && state_reg == dwp_pkg::dwp_d_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_reg_first <= `DWP_WIPER_RST;
      wiper_reg_second <= `DWP_WIPER_RST;
    end else if (instr_take && shift_reg[`DWP_INS_MID]) begin
      if (shift_reg[`DWP_INS_WSEL]) begin
        wiper_reg_second <= `DWP_MIDSCALE;
      end else begin
        wiper_reg_first <= `DWP_MIDSCALE;
      end
    end else if (data_take) begin
      if (wiper_select) begin
        wiper_reg_second <= shift_reg;
      end else begin
        wiper_reg_first <= shift_reg;
      end
    end
  end

  // Outputs hold between transactions; only an accepted instruction moves them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_select <= 1'h0;
      soft_shutdown_bit <= 1'h0;
      logic_out_first <= 1'h0;
      logic_out_second <= 1'h0;
    end else if (instr_take) begin
      wiper_select <= shift_reg[`DWP_INS_WSEL];
      soft_shutdown_bit <= shift_reg[`DWP_INS_SD];
      logic_out_first <= shift_reg[`DWP_INS_OUT1];
      logic_out_second <= shift_reg[`DWP_INS_OUT2];
    end
  end

  // ----------------------------------------------------------------
  // Shutdown
  // ----------------------------------------------------------------
  // Pin is synchronised, so shutdown lags it by three clocks;
  // wiper codes are never touched here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_active <= 1'h0;
    end else begin
      shutdown_active <= ~shutdown_pin_n_n_s | soft_shutdown_bit;
    end
  end

endmodule

// ### rtl/dwp_i2c_master.sv
`timescale 1ns/1ps
`include "dwp_params.svh"
module dwp_i2c_master (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Two-wire bus
  dwp_i2c_if.master bus
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  dwp_pkg::dwp_mst_state_e state_reg;
  logic rw_reg;
  logic [1:0] addr_reg;
  dwp_pkg::dwp_byte_t instr_reg;
  dwp_pkg::dwp_byte_t wdata_reg;
  dwp_pkg::dwp_byte_t rdata_reg;
  logic nack_reg;
  logic wr_acc;
  logic go;
  logic busy;

  assign busy = state_reg != dwp_pkg::dwp_m_idle;
  assign wr_acc = psel & penable & pwrite;
  // A start request while busy is dropped
  assign go = wr_acc && paddr == `DWP_OFF_CTRL && pwdata[`DWP_CTRL_GO] && !busy;
  assign pready = 1'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rw_reg <= 1'h0;
      addr_reg <= 2'h0;
      instr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (wr_acc) begin
      case (paddr)
        `DWP_OFF_CTRL: begin
          rw_reg <= pwdata[`DWP_CTRL_RW];
          addr_reg <= pwdata[`DWP_CTRL_AHI:`DWP_CTRL_ALO];
        end
        `DWP_OFF_INSTR: instr_reg <= pwdata[7:0];
        `DWP_OFF_WDATA: wdata_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data prepared in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'h0;
    end else if (psel && !penable) begin
      pslverr <= 1'h0;
      case (paddr)
        `DWP_OFF_CTRL: prdata <= {28'h0000000, addr_reg, rw_reg, 1'h0};
        `DWP_OFF_INSTR: prdata <= {24'h000000, instr_reg};
        `DWP_OFF_WDATA: prdata <= {24'h000000, wdata_reg};
        `DWP_OFF_STATUS: prdata <= {16'h0000, rdata_reg, 6'h00, nack_reg, busy};
        default: begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'h1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Quarter-bit divider
  // ----------------------------------------------------------------
  localparam logic [5:0] QTR_LAST = 6'(`DWP_QTR_CYC - 1);
  logic [5:0] qcnt_reg;
  logic tick;

  assign tick = busy && qcnt_reg == QTR_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_reg <= 6'h00;
    end else if (!busy || tick) begin
      qcnt_reg <= 6'h00;
    end else begin
      qcnt_reg <= qcnt_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  logic [1:0] phase_reg;
  logic [3:0] bitcnt_reg;
  logic [1:0] idx_reg;
  dwp_pkg::dwp_byte_t shift_reg;
  logic ack_in_reg;
  logic scl_reg;
  logic sda_reg;
  logic reading;
  logic last_byte;

  assign reading = rw_reg && idx_reg == 2'h1;
  assign last_byte = rw_reg ? (idx_reg == 2'h1) : (idx_reg == 2'h2);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= dwp_pkg::dwp_m_idle;
      phase_reg <= 2'h0;
      bitcnt_reg <= 4'h0;
      idx_reg <= 2'h0;
      shift_reg <= 8'h00;
      ack_in_reg <= 1'h1;
      rdata_reg <= 8'h00;
      nack_reg <= 1'h0;
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
    end else if (go) begin
      state_reg <= dwp_pkg::dwp_m_start;
      phase_reg <= 2'h0;
      bitcnt_reg <= 4'h0;
      idx_reg <= 2'h0;
      nack_reg <= 1'h0;
      shift_reg <= {`DWP_ADDR_PREFIX, pwdata[`DWP_CTRL_AHI:`DWP_CTRL_ALO], pwdata[`DWP_CTRL_RW]};
    end else if (tick) begin
      phase_reg <= phase_reg + 2'h1;
      case (state_reg)
        dwp_pkg::dwp_m_start: begin
          case (phase_reg)
            2'h0: sda_reg <= 1'h1;
            2'h1: sda_reg <= 1'h0;
            2'h2: scl_reg <= 1'h0;
            default: state_reg <= dwp_pkg::dwp_m_bits;
          endcase
        end
        dwp_pkg::dwp_m_bits: begin
          case (phase_reg)
            2'h0: sda_reg <= (bitcnt_reg == 4'h8) || reading || shift_reg[7];
            2'h1: scl_reg <= 1'h1;
            2'h2: begin
              if (bitcnt_reg < 4'h8) begin
                shift_reg <= {shift_reg[6:0], bus.sda};
              end else begin
                ack_in_reg <= bus.sda;
              end
            end
            default: begin
              scl_reg <= 1'h0;
              if (bitcnt_reg < 4'h8) begin
                bitcnt_reg <= bitcnt_reg + 4'h1;
              end else begin
                bitcnt_reg <= 4'h0;
                if (reading) begin
                  rdata_reg <= shift_reg;
                end
                if (!reading && ack_in_reg) begin
                  nack_reg <= 1'h1;
                  state_reg <= dwp_pkg::dwp_m_stop;
                end else if (last_byte) begin
                  state_reg <= dwp_pkg::dwp_m_stop;
                end else begin
                  idx_reg <= idx_reg + 2'h1;
                  shift_reg <= (idx_reg == 2'h0) ? instr_reg : wdata_reg;
                end
              end
            end
          endcase
        end
        dwp_pkg::dwp_m_stop: begin
          case (phase_reg)
            2'h0: sda_reg <= 1'h0;
            2'h1: scl_reg <= 1'h1;
            2'h2: sda_reg <= 1'h1;
            default: state_reg <= dwp_pkg::dwp_m_idle;
          endcase
        end
        default: state_reg <= dwp_pkg::dwp_m_idle;
      endcase
    end
  end

  assign bus.m_scl_o = 1'h0;
  assign bus.m_scl_oe_n = scl_reg;
  assign bus.m_sda_o = 1'h0;
  assign bus.m_sda_oe_n = sda_reg;

endmodule

// ### verification/dwp_i2c_sva.sv
`timescale 1ns/1ps
module dwp_i2c_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Wire level and device drive
  input wire logic scl,
  input wire logic s_sda_oe_n,
  // Device state
  input wire dwp_pkg::dwp_byte_t wiper_reg_first,
  input wire dwp_pkg::dwp_byte_t wiper_reg_second,
  input wire logic wiper_select,
  input wire logic logic_out_first,
  input wire logic logic_out_second,
  input wire logic soft_shutdown_bit,
  input wire logic shutdown_pin_n,
  input wire logic shutdown_active
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dev_pull_low: assert property ($fell(s_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device pulled SDA while SCL high");
  a_dev_release_low: assert property ($rose(s_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device released SDA while SCL high");
  a_out_change_low: assert property ($changed({logic_out_first, logic_out_second}) |-> !scl ##1 !scl)
    else $error("logic outputs moved outside SCL low phase");
  a_wiper_change_low: assert property ($changed({wiper_reg_first, wiper_reg_second}) |-> !scl && !$past(scl))
    else $error("wiper moved outside SCL low phase");
  a_sel_change_low: assert property ($changed(wiper_select) |-> !scl)
    else $error("wiper select moved outside SCL low phase");
  a_first_by_sel: assert property ($changed(wiper_reg_first) |-> !wiper_select)
    else $error("first wiper written while second selected");
  a_second_by_sel: assert property ($changed(wiper_reg_second) |-> wiper_select)
    else $error("second wiper written while first selected");
  a_one_wiper_moves: assert property (!($changed(wiper_reg_first) && $changed(wiper_reg_second)))
    else $error("both wipers moved at once");
  a_shutdown_level: assert property ($stable({shutdown_pin_n, soft_shutdown_bit})[*6]
    |-> shutdown_active == (!shutdown_pin_n || soft_shutdown_bit))
    else $error("shutdown state disagrees with pin and soft bit");
  a_pin_forces_off: assert property ($fell(shutdown_pin_n) |-> ##[1:5] shutdown_active)
    else $error("shutdown pin not obeyed in time");
endmodule

// ### verification/dual_wiper_i2c_slave_bench.sv
`timescale 1ns/1ps
`include "dwp_params.svh"
module dual_wiper_i2c_slave_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, addr_seen;
  logic [31:0] pwdata, prdata, rd, st;
  logic strap_hi, strap_lo, sd_pin_n, sel, out1, out2, soft_sd, sd_act, mid_seen;
  dwp_pkg::dwp_byte_t wip1, wip2;
  int n_fail, n_checks;
  dwp_i2c_if bus_if();
  dwp_i2c_master u_dwp_i2c_master (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus_if));
  dwp_i2c_device u_dwp_i2c_device (.pclk(pclk), .presetn(presetn), .bus(bus_if),
    .addr_strap_hi(strap_hi), .addr_strap_lo(strap_lo), .shutdown_pin_n(sd_pin_n),
    .wiper_reg_first(wip1), .wiper_reg_second(wip2), .wiper_select(sel),
    .logic_out_first(out1), .logic_out_second(out2), .soft_shutdown_bit(soft_sd),
    .shutdown_active(sd_act));
  dwp_i2c_sva u_dwp_i2c_sva (.pclk(pclk), .presetn(presetn), .scl(bus_if.scl),
    .s_sda_oe_n(bus_if.s_sda_oe_n), .wiper_reg_first(wip1), .wiper_reg_second(wip2),
    .wiper_select(sel), .logic_out_first(out1), .logic_out_second(out2),
    .soft_shutdown_bit(soft_sd), .shutdown_pin_n(sd_pin_n), .shutdown_active(sd_act));

  // ----------------------------------------------------------------
  // Clock, watchdog and wire monitors
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #1000000;
    n_fail++;
    tally_and_finish();
  end
  // First byte after each start, as it really crosses the wire
  initial begin
    forever begin
      @(negedge bus_if.sda iff bus_if.scl === 1'h1);
      repeat (8) begin
        @(posedge bus_if.scl);
        addr_seen = {addr_seen[6:0], bus_if.sda};
      end
    end
  end
  // Midscale is only visible between instruction and data byte
  always @(posedge pclk) if (wip2 === `DWP_MIDSCALE) mid_seen <= 1'h1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic xfer(input logic rw, input logic hi, input logic lo, input logic [7:0] ins,
                      input logic [7:0] dat);
    apb(1'h1, `DWP_OFF_INSTR, {24'h000000, ins});
    apb(1'h1, `DWP_OFF_WDATA, {24'h000000, dat});
    apb(1'h1, `DWP_OFF_CTRL, {28'h0000000, hi, lo, rw, 1'h1});
    st = 32'h00000001;
    while (st[`DWP_ST_BUSY] !== 1'h0) begin
      repeat (50) @(posedge pclk);
      apb(1'h0, `DWP_OFF_STATUS, 32'h00000000);
      st = rd;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("wipers", {wip1, wip2}, {`DWP_WIPER_RST, `DWP_WIPER_RST});
    chk("idle pins", {out1, out2, sel, soft_sd, sd_act}, 5'h00);
    chk("idle wire", {bus_if.scl, bus_if.sda}, 2'h3);
  endtask
  task automatic t_write_first();
    // Ignored low bits set on purpose
    xfer(1'h0, 1'h1, 1'h0, 8'h17, 8'h3C);
    chk("addr wire", addr_seen, 8'h5C);
    chk("ack", st[`DWP_ST_NACK], 1'h0);
    chk("wiper1", wip1, 8'h3C);
    chk("wiper2", wip2, 8'h80);
    chk("outs", {out1, out2}, 2'h2);
  endtask
  task automatic t_second_midscale();
    xfer(1'h0, 1'h1, 1'h0, 8'h88, 8'h11);
    chk("wipers", {wip1, wip2}, 16'h3C11);
    chk("select", sel, 1'h1);
    chk("outs", {out1, out2}, 2'h1);
    mid_seen <= 1'h0;
    xfer(1'h0, 1'h1, 1'h0, 8'hE0, 8'hA5);
    chk("midscale", mid_seen, 1'h1);
    chk("wiper2", wip2, 8'hA5);
    repeat (10) @(posedge pclk);
    chk("soft sd", {soft_sd, sd_act}, 2'h3);
  endtask
  task automatic t_read();
    xfer(1'h1, 1'h1, 1'h0, 8'h00, 8'h00);
    chk("addr wire", addr_seen, 8'h5D);
    chk("read2", st[15:8], 8'hA5);
    chk("outs hold", {out1, out2, wip2}, 10'h0A5);
    xfer(1'h0, 1'h1, 1'h0, 8'h00, 8'h5A);
    xfer(1'h1, 1'h1, 1'h0, 8'h00, 8'h00);
    chk("read1", st[15:8], 8'h5A);
    repeat (10) @(posedge pclk);
    chk("soft sd off", {soft_sd, sd_act}, 2'h0);
  endtask
  task automatic t_mismatch();
    logic [1:0] bad [3] = '{2'h0, 2'h1, 2'h3};
    foreach (bad[i]) begin
      xfer(1'h0, bad[i][1], bad[i][0], 8'h98, 8'h77);
      chk("nack", st[`DWP_ST_NACK], 1'h1);
      chk("untouched", {wip1, wip2, out1, out2}, 18'h16A94);
    end
    // Moved straps must now be the ones that match
    strap_hi <= 1'h0;
    strap_lo <= 1'h1;
    xfer(1'h0, 1'h0, 1'h1, 8'h00, 8'h3C);
    chk("strap addr wire", addr_seen, 8'h5A);
    chk("strap ack", st[`DWP_ST_NACK], 1'h0);
    chk("strap write", wip1, 8'h3C);
  endtask
  task automatic t_pin_shutdown();
    sd_pin_n <= 1'h0;
    repeat (10) @(posedge pclk);
    chk("pin sd", sd_act, 1'h1);
    chk("codes kept", {wip1, wip2}, 16'h3CA5);
    sd_pin_n <= 1'h1;
    repeat (10) @(posedge pclk);
    chk("pin sd off", sd_act, 1'h0);
  endtask
  task automatic t_unmapped();
    apb(1'h1, 8'h10, 32'h0000FFFF);
    apb(1'h0, 8'h10, 32'h00000000);
    chk("unmapped err", err, 1'h1);
    chk("unmapped data", rd, 32'h00000000);
  endtask

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    strap_hi = 1'h1;
    strap_lo = 1'h0;
    sd_pin_n = 1'h1;
    mid_seen = 1'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_write_first();
    t_second_midscale();
    t_read();
    t_mismatch();
    t_pin_shutdown();
    t_unmapped();
    tally_and_finish();
  end
endmodule
